// >>> rtl/fpm_map.svh
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH
// register byte offsets
`define FPM_OFF_STATUS 4'h0
`define FPM_OFF_SETTING 4'h4
`define FPM_OFF_CTRL 4'h8
// settings limits; level is held as magnitude (0x14 means -20 dBm)
`define FPM_LVL_MIN 6'h0a
`define FPM_LVL_MAX 6'h28
`define FPM_LVL_DEF 6'h14
`define FPM_GAIN_MIN 8'hf6
`define FPM_GAIN_MAX 8'h1e
`define FPM_GAIN_DEF 8'h0a
`define FPM_OUT_MIN 9'h1ec
`define FPM_OUT_MAX 9'h000
`define FPM_ADDR_MAX 5'h1f
`define FPM_CUR_RET 2'h2
// timing
`define FPM_CLK_HZ 40000000
`define FPM_TIMEOUT_S 12
`define FPM_DEBOUNCE_MS 10
`define FPM_SHOW_MS 1000
`define FPM_TIMEOUT_CYC (`FPM_TIMEOUT_S * `FPM_CLK_HZ)
`define FPM_DEBOUNCE_CYC (`FPM_CLK_HZ / 1000 * `FPM_DEBOUNCE_MS)
`define FPM_SHOW_CYC (`FPM_CLK_HZ / 1000 * `FPM_SHOW_MS)
// switch indexes
`define FPM_SW_SEL 0
`define FPM_SW_LEFT 1
`define FPM_SW_RIGHT 2
`define FPM_SW_UP 3
`define FPM_SW_DOWN 4
`define FPM_NSW 5
`endif

// >>> rtl/fpm_pkg.sv
package fpm_pkg;
  typedef enum logic [10:0] {
    ST_LAMP = 11'h001,
    ST_VER = 11'h002,
    ST_NORMAL = 11'h004,
    ST_LEVEL = 11'h008,
    ST_GAIN = 11'h010,
    ST_MUTE = 11'h020,
    ST_REMOTE = 11'h040,
    ST_EXTREF = 11'h080,
    ST_RMODE = 11'h100,
    ST_ADDR = 11'h200,
    ST_SAVE = 11'h400
  } fpm_state_t;
  // nv word: {addr[4:0], rmode, ext_ref, remote, mute, gain[7:0], level[5:0]}
  typedef logic [22:0] fpm_nv_t;
endpackage

// >>> rtl/fpm_ctrl.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`include "fpm_map.svh"

module fpm_ctrl import fpm_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = `FPM_TIMEOUT_CYC,
  parameter int unsigned DEBOUNCE_CYC = `FPM_DEBOUNCE_CYC,
  parameter int unsigned SHOW_CYC = `FPM_SHOW_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`FPM_NSW-1:0] sw_n,
  input wire logic lock_lost,
  input wire logic multidrop_fitted,
  input wire fpm_nv_t nv_rdata,
  output fpm_nv_t nv_wdata_r,
  output logic nv_wr_r,
  output fpm_state_t disp_state_r,
  output logic [1:0] cursor_r,
  output logic save_yes_r,
  output logic [5:0] level_r,
  output logic signed [7:0] gain_r,
  output logic mute_r,
  output logic remote_r,
  output logic ext_ref_r,
  output logic rmode_r,
  output logic [4:0] addr_r,
  output logic alarm_led_r,
  output logic mute_led_r,
  output logic remote_led_r,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic rst_s1, srst_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      srst_n <= rst_s1;
    end
  end

  function automatic logic out_ok(input logic [5:0] l, input logic signed [7:0] g);
    logic signed [8:0] o;
    o = 9'({g[7], g}) - 9'({3'h0, l});
    return (o <= signed'(`FPM_OUT_MAX)) && (o >= signed'(`FPM_OUT_MIN));
  endfunction

  // switches: two-flop sync, then a hold-stable counter; event on the press edge
  logic [`FPM_NSW-1:0] ev;
  logic panel_lock_r;
  genvar gi;
  generate
    for (gi = 0; gi < `FPM_NSW; gi++) begin : g_sw
      logic s1, s2, deb, prev;
      logic [31:0] cnt;
      // pins sampled as they stand; the inversion waits until after the second flop
      always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
        end else begin
          s1 <= sw_n[gi];
          s2 <= s1;
        end
      end
      always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
          cnt <= 32'h0;
          deb <= 1'b0;
          prev <= 1'b0;
        end else begin
          prev <= deb;
          if (!s2 == deb) cnt <= 32'h0;
          else if (cnt >= DEBOUNCE_CYC - 1) begin
            deb <= !s2;
            cnt <= 32'h0;
          end else cnt <= cnt + 32'h1;
        end
      end
      assign ev[gi] = deb & ~prev & ~panel_lock_r;
    end
  endgenerate

  logic lk1, lk_s, md1, md_s;
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      lk1 <= 1'b0;
      lk_s <= 1'b0;
      md1 <= 1'b0;
      md_s <= 1'b0;
    end else begin
      lk1 <= lock_lost;
      lk_s <= lk1;
      md1 <= multidrop_fitted;
      md_s <= md1;
    end
  end

  wire sel_ev = ev[`FPM_SW_SEL];
  wire up_ev = ev[`FPM_SW_UP];
  wire dn_ev = ev[`FPM_SW_DOWN];
  wire vert_ev = up_ev | dn_ev;
  wire any_ev = |ev;

  fpm_state_t state_r;
  fpm_nv_t saved_r;
  logic [31:0] show_cnt_r, idle_cnt_r;
  wire in_session = !(state_r inside {ST_LAMP, ST_VER, ST_NORMAL});
  wire timeout = in_session && !any_ev && (idle_cnt_r == TIMEOUT_CYC - 1);
  wire on_ret = (cursor_r == `FPM_CUR_RET);
  fpm_nv_t live;
  assign live = {addr_r, rmode_r, ext_ref_r, remote_r, mute_r, gain_r, level_r};

  // idle timer only runs inside a session
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) idle_cnt_r <= 32'h0;
    else if (!in_session || any_ev) idle_cnt_r <= 32'h0;
    else if (!timeout) idle_cnt_r <= idle_cnt_r + 32'h1;
  end

  // menu sequencing
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      state_r <= ST_LAMP;
      show_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        ST_LAMP, ST_VER: begin
          if (show_cnt_r >= SHOW_CYC - 1) begin
            show_cnt_r <= 32'h0;
            state_r <= (state_r == ST_LAMP) ? ST_VER : ST_NORMAL;
          end else show_cnt_r <= show_cnt_r + 32'h1;
        end
        ST_NORMAL: if (sel_ev) state_r <= ST_LEVEL;
        ST_SAVE: begin
          if (timeout) state_r <= ST_NORMAL;
          else if (sel_ev) state_r <= ST_NORMAL;
        end
        default: begin
          if (timeout) state_r <= ST_NORMAL;
          else if (sel_ev) begin
            if (on_ret) state_r <= ST_SAVE;
            else begin
              case (state_r)
                ST_LEVEL: state_r <= ST_GAIN;
                ST_GAIN: state_r <= ST_MUTE;
                ST_MUTE: state_r <= ST_REMOTE;
                ST_REMOTE: state_r <= ST_EXTREF;
                ST_EXTREF: state_r <= md_s ? ST_RMODE : ST_SAVE;
                ST_RMODE: state_r <= ST_ADDR;
                default: state_r <= ST_SAVE;
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) disp_state_r <= ST_LAMP;
    else disp_state_r <= state_r;
  end

  // cursor: 0 tens digit, 1 units digit, 2 return marker
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) cursor_r <= 2'h1;
    else if (!in_session || sel_ev) cursor_r <= 2'h1;
    else if (ev[`FPM_SW_LEFT] && cursor_r != 2'h0) cursor_r <= cursor_r - 2'h1;
    else if (ev[`FPM_SW_RIGHT] && !on_ret) cursor_r <= cursor_r + 2'h1;
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) save_yes_r <= 1'b0;
    else if (state_r != ST_SAVE) save_yes_r <= 1'b0;
    else if (vert_ev) save_yes_r <= ~save_yes_r;
  end

  // candidate values for level and gain edits
  logic [5:0] lvl_try;
  logic signed [7:0] gain_try, gstep;
  always_comb begin
    lvl_try = up_ev ? level_r - 6'h01 : level_r + 6'h01;
    gstep = (cursor_r == 2'h0) ? 8'sh0a : 8'sh01;
    gain_try = up_ev ? gain_r + gstep : gain_r - gstep;
  end
  wire lvl_ok = (lvl_try >= `FPM_LVL_MIN) && (lvl_try <= `FPM_LVL_MAX)
                && out_ok(lvl_try, gain_r);
  wire gain_ok = (gain_try >= signed'(`FPM_GAIN_MIN))
                 && (gain_try <= signed'(`FPM_GAIN_MAX))
                 && out_ok(level_r, gain_try);
  wire edit = vert_ev && !on_ret && !timeout && !sel_ev;
  wire commit = (state_r == ST_SAVE) && sel_ev && save_yes_r && !timeout;
  wire revert = timeout || ((state_r == ST_SAVE) && sel_ev && !save_yes_r);

  // live settings feed the signal path at once; saved copy holds the session start
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      level_r <= `FPM_LVL_DEF;
      gain_r <= `FPM_GAIN_DEF;
      {addr_r, rmode_r, ext_ref_r, remote_r, mute_r} <= 9'h000;
    end else if (state_r == ST_LAMP && show_cnt_r == 32'h0) begin
      {addr_r, rmode_r, ext_ref_r, remote_r, mute_r, gain_r, level_r} <= nv_rdata;
    end else if (revert) begin
      {addr_r, rmode_r, ext_ref_r, remote_r, mute_r, gain_r, level_r} <= saved_r;
    end else if (edit) begin
      case (state_r)
        ST_LEVEL: if (lvl_ok) level_r <= lvl_try;
        ST_GAIN: if (gain_ok) gain_r <= gain_try;
        ST_MUTE: mute_r <= ~mute_r;
        ST_REMOTE: remote_r <= ~remote_r;
        ST_EXTREF: ext_ref_r <= ~ext_ref_r;
        ST_RMODE: rmode_r <= ~rmode_r;
        ST_ADDR: begin
          if (up_ev && addr_r != `FPM_ADDR_MAX) addr_r <= addr_r + 5'h01;
          else if (dn_ev && addr_r != 5'h00) addr_r <= addr_r - 5'h01;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      saved_r <= '0;
      nv_wdata_r <= '0;
      nv_wr_r <= 1'b0;
    end else begin
      nv_wr_r <= commit;
      if (state_r == ST_LAMP && show_cnt_r == 32'h0) saved_r <= nv_rdata;
      else if (commit) begin
        saved_r <= live;
        nv_wdata_r <= live;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      alarm_led_r <= 1'b0;
      mute_led_r <= 1'b0;
      remote_led_r <= 1'b0;
    end else begin
      alarm_led_r <= lk_s;
      mute_led_r <= mute_r;
      remote_led_r <= remote_r;
    end
  end

  // avalon slave: one wait cycle, then answer; read data latched as the wait cycle ends, write taken at the end of the answer cycle
  wire req = avs_read | avs_write;
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= !(req && avs_waitrequest);
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) panel_lock_r <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == `FPM_OFF_CTRL)
      panel_lock_r <= avs_writedata[0];
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) avs_readdata <= 32'h0;
    else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `FPM_OFF_STATUS:
          avs_readdata <= {15'h0, md_s, lk_s, in_session, save_yes_r, cursor_r, state_r};
        `FPM_OFF_SETTING: avs_readdata <= {9'h0, live};
        `FPM_OFF_CTRL: avs_readdata <= {31'h0, panel_lock_r};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // checks
  sequence s_save_press;
    state_r == ST_SAVE && sel_ev && !timeout;
  endsequence
  sequence s_back_normal;
    state_r == ST_NORMAL && disp_state_r == ST_SAVE;
  endsequence

  a_level_range: assert property (@(posedge ref_clk) disable iff (!srst_n)
    state_r inside {ST_LAMP, ST_VER} || (level_r >= `FPM_LVL_MIN && level_r <= `FPM_LVL_MAX))
    else $error("input level out of range");
  a_gain_range: assert property (@(posedge ref_clk) disable iff (!srst_n)
    edit && state_r == ST_GAIN |=>
      gain_r >= signed'(`FPM_GAIN_MIN) && gain_r <= signed'(`FPM_GAIN_MAX))
    else $error("gain out of range");
  a_output_window: assert property (@(posedge ref_clk) disable iff (!srst_n)
    edit && state_r inside {ST_LEVEL, ST_GAIN} |=> out_ok(level_r, gain_r))
    else $error("output level window broken");
  a_alarm_follow: assert property (@(posedge ref_clk) disable iff (!srst_n)
    lock_lost [*3] |-> ##1 alarm_led_r)
    else $error("alarm missed lock loss");
  a_leds_track: assert property (@(posedge ref_clk) disable iff (!srst_n)
    $changed(mute_r) |=> mute_led_r == $past(mute_r) ##0 remote_led_r == $past(remote_r))
    else $error("indicator not following setting");
  a_timeout_abort: assert property (@(posedge ref_clk) disable iff (!srst_n)
    timeout |=> state_r == ST_NORMAL && live == $past(saved_r))
    else $error("idle session not abandoned");
  a_save_commit: assert property (@(posedge ref_clk) disable iff (!srst_n)
    s_save_press ##0 save_yes_r |=> s_back_normal ##0 nv_wr_r && saved_r == $past(live))
    else $error("yes answer did not commit");
  a_no_restore: assert property (@(posedge ref_clk) disable iff (!srst_n)
    s_save_press ##0 !save_yes_r |=> s_back_normal ##0 !nv_wr_r && live == $past(saved_r))
    else $error("no answer did not restore");
  a_return_jump: assert property (@(posedge ref_clk) disable iff (!srst_n)
    in_session && state_r != ST_SAVE && on_ret && sel_ev && !timeout |=> state_r == ST_SAVE)
    else $error("return marker did not reach save prompt");
  a_idle_restart: assert property (@(posedge ref_clk) disable iff (!srst_n)
    in_session && any_ev |=> idle_cnt_r == 32'h0)
    else $error("idle timer not restarted");
  a_boot_order: assert property (@(posedge ref_clk) disable iff (!srst_n)
    state_r == ST_LAMP ##1 state_r != ST_LAMP |-> state_r == ST_VER)
    else $error("power-up screens out of order");
  a_menu_order: assert property (@(posedge ref_clk) disable iff (!srst_n)
    state_r == ST_EXTREF && sel_ev && !on_ret && !timeout |=>
      state_r == ($past(md_s) ? ST_RMODE : ST_SAVE))
    else $error("menu order wrong after reference menu");
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!srst_n)
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_cursor_step: assert property (@(posedge ref_clk) disable iff (!srst_n)
    in_session && !sel_ev && ev[`FPM_SW_LEFT] && cursor_r != 2'h0 |=>
      cursor_r == $past(cursor_r) - 2'h1)
    else $error("cursor did not step left");
  a_level_step: assert property (@(posedge ref_clk) disable iff (!srst_n)
    edit && state_r == ST_LEVEL |=> level_r == $past(level_r)
      || level_r == $past(level_r) + 6'h01 || level_r == $past(level_r) - 6'h01)
    else $error("level moved by more than one step");
  a_gain_digit: assert property (@(posedge ref_clk) disable iff (!srst_n)
    edit && state_r == ST_GAIN && cursor_r == 2'h0 |=> gain_r == $past(gain_r)
      || gain_r == $past(gain_r) + 8'sh0a || gain_r == $past(gain_r) - 8'sh0a)
    else $error("tens digit did not step by ten");
  a_item_toggle: assert property (@(posedge ref_clk) disable iff (!srst_n)
    edit && state_r == ST_MUTE |=> mute_r != $past(mute_r))
    else $error("two-choice item did not toggle");
  a_answer_toggle: assert property (@(posedge ref_clk) disable iff (!srst_n)
    state_r == ST_SAVE && vert_ev |=> save_yes_r != $past(save_yes_r))
    else $error("save answer did not toggle");
  a_store_on_yes: assert property (@(posedge ref_clk) disable iff (!srst_n)
    nv_wr_r |-> $past(state_r) == ST_SAVE && $past(save_yes_r) && $past(sel_ev))
    else $error("settings stored without a yes answer");
  a_boot_load: assert property (@(posedge ref_clk) disable iff (!srst_n)
    state_r == ST_LAMP && show_cnt_r == 32'h0 |=> live == $past(nv_rdata))
    else $error("stored settings not restored at power-up");
endmodule // fpm_ctrl

// >>> tb/fpm_operator.sv
// operator at the switches plus the settings store the panel saves into
module fpm_operator import fpm_pkg::*; #(
  parameter fpm_nv_t NV_INIT = 23'h000294
) (
  input wire logic ref_clk,
  output logic [4:0] sw_n,
  input wire fpm_nv_t nv_wdata_r,
  input wire logic nv_wr_r,
  output fpm_nv_t nv_rdata,
  output int n_writes
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sw_n = 5'h1f;
    nv_rdata = NV_INIT;
    n_writes = 0;
  end

  // store is always ready, so a pulse lands at the edge that sees it
  always @(posedge ref_clk) begin
    if (nv_wr_r === 1'b1) begin
      nv_rdata <= nv_wdata_r;
      n_writes <= n_writes + 1;
    end
  end

  // pins idle high through the pull-ups; release is held long enough to re-arm
  task automatic push(input int idx, input int hold);
    @(posedge ref_clk);
    sw_n[idx] <= 1'b0;
    repeat (hold) @(posedge ref_clk);
    sw_n[idx] <= 1'b1;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule // fpm_operator

// >>> tb/fpm_ctrl_tb.sv
`include "fpm_map.svh"

module fpm_ctrl_tb import fpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEL = `FPM_SW_SEL;
  localparam int LFT = `FPM_SW_LEFT;
  localparam int RGT = `FPM_SW_RIGHT;
  localparam int UP = `FPM_SW_UP;
  localparam int DN = `FPM_SW_DOWN;
  logic ref_clk, rst_n, lock_lost, multidrop_fitted, nv_wr_r, save_yes_r;
  logic [4:0] sw_n, addr_r;
  fpm_nv_t nv_rdata, nv_wdata_r;
  fpm_state_t disp_state_r;
  logic [1:0] cursor_r;
  logic [5:0] level_r;
  logic signed [7:0] gain_r;
  logic mute_r, remote_r, ext_ref_r, rmode_r, alarm_led_r, mute_led_r, remote_led_r;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, d;
  int n_writes;
  int miscompares = 0;
  int n_checks = 0;
  fpm_state_t order [7] = '{ST_LEVEL, ST_GAIN, ST_MUTE, ST_REMOTE, ST_EXTREF, ST_RMODE, ST_ADDR};

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  fpm_ctrl #(.TIMEOUT_CYC(200), .DEBOUNCE_CYC(4), .SHOW_CYC(8)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .sw_n(sw_n), .lock_lost(lock_lost),
    .multidrop_fitted(multidrop_fitted), .nv_rdata(nv_rdata), .nv_wdata_r(nv_wdata_r),
    .nv_wr_r(nv_wr_r), .disp_state_r(disp_state_r), .cursor_r(cursor_r),
    .save_yes_r(save_yes_r), .level_r(level_r), .gain_r(gain_r), .mute_r(mute_r),
    .remote_r(remote_r), .ext_ref_r(ext_ref_r), .rmode_r(rmode_r), .addr_r(addr_r),
    .alarm_led_r(alarm_led_r), .mute_led_r(mute_led_r), .remote_led_r(remote_led_r),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  fpm_operator i_op (.ref_clk(ref_clk), .sw_n(sw_n), .nv_wdata_r(nv_wdata_r),
    .nv_wr_r(nv_wr_r), .nv_rdata(nv_rdata), .n_writes(n_writes));

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pr(input int idx);
    i_op.push(idx, 12);
  endtask

  // bounded wait for the screen to move on from s
  task automatic wait_leave(input fpm_state_t s, input int bound);
    int k;
    for (k = 0; k < bound && disp_state_r === s; k++) @(posedge ref_clk);
    if (disp_state_r === s) begin
      miscompares++;
      report_and_stop;
    end
  endtask

  task automatic bus_wait;
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) return;
    end
    miscompares++;
    report_and_stop;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait;
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    bus_wait;
    avs_write <= 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    lock_lost = 1'b0;
    multidrop_fitted = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge ref_clk);
    chk("screen", disp_state_r, ST_LAMP);
    rst_n <= 1'b1;
    wait_leave(ST_LAMP, 40);
    chk("screen", disp_state_r, ST_VER);
    wait_leave(ST_VER, 40);
    chk("screen", disp_state_r, ST_NORMAL);
    chk("level", level_r, 32'h14);
    lock_lost <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("alarm", alarm_led_r, 32'h1);
    lock_lost <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("alarm", alarm_led_r, 32'h0);
    // panel lock over the bus, plus an unmapped read
    bus_wr(4'h8, 32'h1);
    bus_rd(4'h8, d);
    chk("ctrl", d, 32'h1);
    bus_rd(4'hc, d);
    chk("unmapped", d, 32'h0);
    pr(SEL);
    chk("screen", disp_state_r, ST_NORMAL);
    bus_wr(4'h8, 32'h0);
    bus_rd(4'h0, d);
    chk("status", d[10:0], ST_NORMAL);
    // session kept by a yes answer
    pr(SEL);
    chk("screen", disp_state_r, ST_LEVEL);
    pr(UP);
    chk("level", level_r, 32'h13);
    repeat (10) pr(UP);
    chk("level", level_r, 32'h0a);
    pr(SEL);
    chk("screen", disp_state_r, ST_GAIN);
    pr(UP);
    chk("gain", {gain_r}, 32'h0a);
    pr(DN);
    chk("gain", {gain_r}, 32'h09);
    pr(LFT);
    chk("cursor", cursor_r, 32'h0);
    pr(DN);
    chk("gain", {gain_r}, 32'hff);
    pr(DN);
    chk("gain", {gain_r}, 32'hff);
    pr(SEL);
    pr(UP);
    chk("mute led", mute_led_r, 32'h1);
    pr(DN);
    chk("mute", mute_r, 32'h0);
    pr(DN);
    chk("mute", mute_r, 32'h1);
    pr(SEL);
    pr(UP);
    chk("remote led", remote_led_r, 32'h1);
    pr(SEL);
    chk("screen", disp_state_r, ST_EXTREF);
    pr(SEL);
    chk("screen", disp_state_r, ST_SAVE);
    pr(UP);
    chk("answer", save_yes_r, 32'h1);
    pr(SEL);
    chk("screen", disp_state_r, ST_NORMAL);
    chk("stored", nv_rdata, 32'h00ffca);
    chk("store data", nv_wdata_r, 32'h00ffca);
    bus_rd(4'h4, d);
    chk("setting", d, 32'h00ffca);
    // second power-up restores the stored word
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_leave(ST_LAMP, 40);
    wait_leave(ST_VER, 40);
    chk("gain", {gain_r}, 32'hff);
    chk("mute", mute_r, 32'h1);
    // session dropped by a no answer from the return marker
    multidrop_fitted <= 1'b1;
    pr(SEL);
    i_op.push(DN, 2);
    chk("level", level_r, 32'h0a);
    pr(DN);
    chk("level", level_r, 32'h0b);
    pr(SEL);
    pr(RGT);
    chk("cursor", cursor_r, 32'h2);
    pr(SEL);
    chk("screen", disp_state_r, ST_SAVE);
    pr(SEL);
    chk("screen", disp_state_r, ST_NORMAL);
    chk("level", level_r, 32'h0a);
    // full menu order with the option fitted, then idle abandon
    foreach (order[i]) begin
      pr(SEL);
      chk("screen", disp_state_r, order[i]);
      if (order[i] inside {ST_EXTREF, ST_RMODE}) begin
        pr(DN);
        chk("option", {ext_ref_r, rmode_r}, (order[i] == ST_EXTREF) ? 32'h2 : 32'h3);
      end
    end
    repeat (100) @(posedge ref_clk);
    pr(UP);
    chk("addr", addr_r, 32'h1);
    repeat (150) @(posedge ref_clk);
    chk("screen", disp_state_r, ST_ADDR);
    wait_leave(ST_ADDR, 100);
    chk("screen", disp_state_r, ST_NORMAL);
    chk("addr", addr_r, 32'h0);
    chk("option", {ext_ref_r, rmode_r}, 32'h0);
    chk("writes", n_writes, 32'h1);
    report_and_stop;
  end
endmodule // fpm_ctrl_tb
